// ==== include/pofc_pkg.sv ====
// Purpose: shared constants and types of the overcurrent fault configuration block
// Assumes: 100 MHz clk; command codes arrive already decoded from the bus target
// Notes:   reset values are plain defaults; software programs the real ones
package pofc_pkg;

  // ==========================================================================
  // command codes of the register group
  localparam logic [7:0] CMD_DELAY_UNIT = 8'hc8;
  localparam logic [7:0] CMD_ADDR_CFG   = 8'hc9;
  localparam logic [7:0] CMD_OC_RESP    = 8'hca;
  localparam logic [7:0] CMD_AVG_LIMIT  = 8'hd0;
  localparam logic [7:0] CMD_FAST_LIMIT = 8'hd1;

  // ==========================================================================
  // field positions
  localparam int CFG_PG_POL_BIT   = 39;
  localparam int CFG_CTRL_POL_BIT = 32;
  localparam int CFG_BASE_LSB     = 24;
  localparam int CFG_OFFS_LSB     = 17;
  localparam int CFG_STRAP_EN_BIT = 16;
  localparam int RSP_ACT_LSB      = 6;
  localparam int RSP_RETRY_LSB    = 3;
  localparam int RSP_TIME_LSB     = 0;
  localparam int DU_IOUT_LSB      = 2;

  // writable bits of the 40-bit address config; the rest read as zero
  localparam logic [39:0] CFG_RW_MASK = 40'h81_ffff_0000;

  // ==========================================================================
  // reset values
  localparam logic [39:0] CFG_RESET        = 40'h00_0000_0000;
  localparam logic [7:0]  RESP_RESET       = 8'h00;
  localparam logic [7:0]  DELAY_UNIT_RESET = 8'h00;
  localparam logic [15:0] AVG_LIMIT_RESET  = 16'h0000;
  localparam logic [15:0] FAST_LIMIT_RESET = 16'h0000;

  // ==========================================================================
  // response codes and retry settings
  localparam logic [1:0] ACT_IGNORE     = 2'h0;
  localparam logic [1:0] ACT_SHUT_RETRY = 2'h3;
  localparam logic [2:0] RETRY_NONE     = 3'h0;
  localparam logic [2:0] RETRY_FOREVER  = 3'h7;

  // delay unit shifts: 1, 4, 16 and 256 ms
  localparam logic [3:0] DU_SHIFT_1MS   = 4'h0;
  localparam logic [3:0] DU_SHIFT_4MS   = 4'h2;
  localparam logic [3:0] DU_SHIFT_16MS  = 4'h4;
  localparam logic [3:0] DU_SHIFT_256MS = 4'h8;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_UNIT_NS    = 1000000;
  localparam int MS_CYCLES     = MS_UNIT_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // types
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [39:0] data;
  } pofc_cmd_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_LIMIT,
    ST_RETRY_WAIT,
    ST_LATCHED
  } pofc_state_t;

endpackage

// ==== hdl/pofc_retry_timer.sv ====
// Purpose: millisecond timer for delay and retry times of the fault response
// Assumes: start is a one-cycle pulse; a new start restarts the count
// Notes:   count is 2^(unit shift + time field) ms, 1 ms up to 32768 ms
`timescale 1ns/1ps
module pofc_retry_timer #(
  parameter int unsigned MS_CYCLES = pofc_pkg::MS_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [1:0] unit_sel,
  input  wire logic [2:0] time_exp,
  output logic            done
);

  // ==========================================================================
  // length of the run in milliseconds
  logic [31:0] pre;
  logic [15:0] ms_left;
  logic        run;
  wire  [3:0]  unit_shift = (unit_sel == 2'h0) ? pofc_pkg::DU_SHIFT_1MS :
                            (unit_sel == 2'h1) ? pofc_pkg::DU_SHIFT_4MS :
                            (unit_sel == 2'h2) ? pofc_pkg::DU_SHIFT_16MS :
                                                 pofc_pkg::DU_SHIFT_256MS;
  wire  [3:0]  total_shift = unit_shift + {1'b0, time_exp};
  wire  [15:0] load_ms     = 16'h0001 << total_shift;
  wire         ms_tick     = run && (pre == MS_CYCLES - 1);

  // prescaler and millisecond down-counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run     <= 1'b0;
      pre     <= 32'h0;
      ms_left <= 16'h0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        run     <= 1'b1;
        pre     <= 32'h0;
        ms_left <= load_ms;
      end else if (ms_tick) begin
        pre <= 32'h0;
        if (ms_left == 16'h0001) begin
          run  <= 1'b0;
          done <= 1'b1;
        end else begin
          ms_left <= ms_left - 16'h0001;
        end
      end else if (run) begin
        pre <= pre + 32'h1;
      end
    end
  end

endmodule

// ==== hdl/pofc_top.sv ====
// Purpose: address/polarity config and fast overcurrent fault response of a power module
// Assumes: bus target decodes frames into one command per cycle on cmd
// Notes:   pins pass two flip-flops; sequencing logic inputs are on clk
//
// Overview of operation
// - target address is config bits 31:24 plus the chosen offset
// - with strap disabled the seven-bit programmed offset is added
// - strap enable bit: 0 programmed offset, 1 strapping resistor offset
// - power-good pin active high when its polarity bit is 1, else low
// - on/off pin read active high when its polarity bit is 1, else low
// - any response code: fast fault sets status and notifies host
// - code 00 keeps running forever with current clamped at the limit
// - code 11 limits for the delay time, then applies the retry setting
// - retry 000 disables output with no restart until fault cleared
// - retry 1 to 6 restarts that many times, then latches off
// - restart attempts are spaced by retry time times delay unit
// - retry 111 restarts until commanded off, bias lost or other fault
// - time field counts two to the n delay units, 1 to 128
// - averaged overcurrent limit stored as 16-bit linear number
// - fast overcurrent limit stored and read back as 16-bit integer
// - delay unit field picks 1, 4, 16 or 256 ms
`timescale 1ns/1ps
module pofc_top #(
  parameter int unsigned MS_CYCLES  = pofc_pkg::MS_CYCLES,
  parameter bit          NOTIFY_EN  = 1'b1
) (
  input  wire logic                cmd_valid_unused_guard,
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  pofc_pkg::pofc_cmd_t      cmd,
  input  wire logic                oc_fast_detect,
  input  wire logic                ctrl_pin,
  input  wire logic                bias_ok,
  input  wire logic [3:0]          strap_address_input_one,
  input  wire logic [3:0]          strap_address_input_two,
  input  wire logic                operation_on,
  input  wire logic                other_fault,
  input  wire logic                fault_clear,
  input  wire logic                power_good_int,
  output logic                     rd_valid,
  output logic                     rd_unmapped,
  output logic [39:0]              rd_data,
  output logic [7:0]               target_address,
  output logic                     power_good_pin,
  output logic                     output_enable,
  output logic                     current_clamp,
  output logic                     fault_status,
  output logic                     host_alert,
  output logic [15:0]              avg_limit,
  output logic [15:0]              fast_limit
);

  // ==========================================================================
  // pin synchronisers; stage one is read only by stage two
  localparam int SW = 11;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  wire  [SW-1:0] pins_raw = {oc_fast_detect, ctrl_pin, bias_ok,
                             strap_address_input_one, strap_address_input_two};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
    end
  end

  wire       oc_s    = sync2[10];
  wire       ctrl_s  = sync2[9];
  wire       bias_s  = sync2[8];
  wire [6:0] strap_s = {sync2[2:0], sync2[7:4]};

  // ==========================================================================
  // register storage
  logic [39:0] cfg;
  logic [7:0]  resp;
  logic [7:0]  dunit;

  wire wr        = cmd.valid && cmd.write;
  wire hit_du    = cmd.code == pofc_pkg::CMD_DELAY_UNIT;
  wire hit_cfg   = cmd.code == pofc_pkg::CMD_ADDR_CFG;
  wire hit_resp  = cmd.code == pofc_pkg::CMD_OC_RESP;
  wire hit_avg   = cmd.code == pofc_pkg::CMD_AVG_LIMIT;
  wire hit_fast  = cmd.code == pofc_pkg::CMD_FAST_LIMIT;
  wire hit_any   = hit_du || hit_cfg || hit_resp || hit_avg || hit_fast;

  // read mux; unmapped codes read zero
  wire [39:0] rd_mux = hit_cfg  ? cfg :
                       hit_resp ? {32'h0, resp} :
                       hit_du   ? {32'h0, dunit} :
                       hit_avg  ? {24'h0, avg_limit} :
                       hit_fast ? {24'h0, fast_limit} : 40'h0;

  // config writes store only the writable bits; the other registers store every bit of their width
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg        <= pofc_pkg::CFG_RESET;
      resp       <= pofc_pkg::RESP_RESET;
      dunit      <= pofc_pkg::DELAY_UNIT_RESET;
      avg_limit  <= pofc_pkg::AVG_LIMIT_RESET;
      fast_limit <= pofc_pkg::FAST_LIMIT_RESET;
    end else if (wr) begin
      if (hit_cfg)  cfg        <= cmd.data & pofc_pkg::CFG_RW_MASK;
      if (hit_resp) resp       <= cmd.data[7:0];
      if (hit_du)   dunit      <= cmd.data[7:0];
      if (hit_avg)  avg_limit  <= cmd.data[15:0];
      if (hit_fast) fast_limit <= cmd.data[15:0];
    end
  end

  // read answer one cycle after the command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid    <= 1'b0;
      rd_unmapped <= 1'b0;
      rd_data     <= 40'h0;
    end else begin
      rd_valid    <= cmd.valid && !cmd.write;
      rd_unmapped <= cmd.valid && !hit_any;
      if (cmd.valid && !cmd.write) rd_data <= rd_mux;
    end
  end

  // ==========================================================================
  // address and pin polarity
  wire [7:0] base_w   = cfg[pofc_pkg::CFG_BASE_LSB +: 8];
  wire [6:0] prog_off = cfg[pofc_pkg::CFG_OFFS_LSB +: 7];
  wire       strap_en = cfg[pofc_pkg::CFG_STRAP_EN_BIT];
  wire [6:0] sel_off  = strap_en ? strap_s : prog_off;
  wire [7:0] addr_sum = base_w + {1'b0, sel_off};
  wire       pg_pol   = cfg[pofc_pkg::CFG_PG_POL_BIT];
  wire       ctl_pol  = cfg[pofc_pkg::CFG_CTRL_POL_BIT];
  wire       ctrl_on  = ctl_pol ? ctrl_s : !ctrl_s;
  wire       on_req   = ctrl_on && operation_on && bias_s && !other_fault;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_address <= 8'h0;
      power_good_pin <= 1'b0;
    end else begin
      target_address <= addr_sum;
      power_good_pin <= pg_pol ? power_good_int : !power_good_int;
    end
  end

  // ==========================================================================
  // fault response sequencer
  pofc_pkg::pofc_state_t state;
  pofc_pkg::pofc_state_t next_state;
  logic [2:0] attempts;
  logic [2:0] next_attempts;
  logic       tmr_start;
  logic       tmr_done;
  logic       oc_d;

  wire [1:0] act      = resp[pofc_pkg::RSP_ACT_LSB +: 2];
  wire [2:0] retries  = resp[pofc_pkg::RSP_RETRY_LSB +: 3];
  wire [2:0] time_fld = resp[pofc_pkg::RSP_TIME_LSB +: 3];
  wire [1:0] iout_du  = dunit[pofc_pkg::DU_IOUT_LSB +: 2];
  wire       running  = (state == pofc_pkg::ST_RUN) || (state == pofc_pkg::ST_LIMIT);
  wire       oc_evt   = running && oc_s && !oc_d;
  wire       give_up  = (retries == pofc_pkg::RETRY_NONE) ||
                        ((retries != pofc_pkg::RETRY_FOREVER) && (attempts >= retries));

  // codes 01/10 skip the limiting delay and go straight to retry handling
  always_comb begin
    next_state    = state;
    next_attempts = attempts;
    tmr_start     = 1'b0;
    unique case (state)
      pofc_pkg::ST_OFF: begin
        if (on_req) next_state = pofc_pkg::ST_RUN;
      end
      pofc_pkg::ST_RUN: begin
        if (oc_s && act == pofc_pkg::ACT_SHUT_RETRY) begin
          next_state = pofc_pkg::ST_LIMIT;
          tmr_start  = 1'b1;
        end else if (oc_s && act != pofc_pkg::ACT_IGNORE) begin
          next_state = give_up ? pofc_pkg::ST_LATCHED : pofc_pkg::ST_RETRY_WAIT;
          tmr_start  = !give_up;
        end
      end
      pofc_pkg::ST_LIMIT: begin
        if (!oc_s) begin
          next_state = pofc_pkg::ST_RUN;
        end else if (tmr_done) begin
          next_state = give_up ? pofc_pkg::ST_LATCHED : pofc_pkg::ST_RETRY_WAIT;
          tmr_start  = !give_up;
        end
      end
      pofc_pkg::ST_RETRY_WAIT: begin
        if (tmr_done) begin
          next_state    = pofc_pkg::ST_RUN;
          next_attempts = (retries == pofc_pkg::RETRY_FOREVER) ? attempts
                                                                : attempts + 3'h1;
        end
      end
      pofc_pkg::ST_LATCHED: begin
        if (fault_clear) next_state = pofc_pkg::ST_OFF;
      end
    endcase
    if (!on_req) next_state = pofc_pkg::ST_OFF;
    if (fault_clear || state == pofc_pkg::ST_OFF) next_attempts = 3'h0;
  end

  // time field and delay unit set both delay and retry spacing
  pofc_retry_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk       (clk),
    .rst_n     (rst_n),
    .start     (tmr_start),
    .unit_sel  (iout_du),
    .time_exp  (time_fld),
    .done      (tmr_done)
  );

  wire next_on    = (next_state == pofc_pkg::ST_RUN) || (next_state == pofc_pkg::ST_LIMIT);
  wire next_clamp = (next_state == pofc_pkg::ST_LIMIT) ||
                    (next_state == pofc_pkg::ST_RUN && oc_s && act == pofc_pkg::ACT_IGNORE);

  // state, outputs and sticky status; a new event wins over a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= pofc_pkg::ST_OFF;
      attempts      <= 3'h0;
      oc_d          <= 1'b0;
      output_enable <= 1'b0;
      current_clamp <= 1'b0;
      fault_status  <= 1'b0;
      host_alert    <= 1'b0;
    end else begin
      state         <= next_state;
      attempts      <= next_attempts;
      oc_d          <= oc_s;
      output_enable <= next_on;
      current_clamp <= next_clamp;
      if (oc_evt) fault_status <= 1'b1;
      else if (fault_clear) fault_status <= 1'b0;
      if (oc_evt && NOTIFY_EN) host_alert <= 1'b1;
      else if (fault_clear) host_alert <= 1'b0;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_addr_prog: assert property (!strap_en && $stable(cfg) |=>
      target_address == $past(base_w) + {1'b0, $past(prog_off)})
    else $error("programmed address offset not applied");
  a_addr_strap: assert property (strap_en && $stable(cfg) && $stable(strap_s) |=>
      target_address == $past(base_w) + {1'b0, $past(strap_s)})
    else $error("strap address offset not applied");
  a_pg_polarity: assert property (rst_n |=> power_good_pin ==
      ($past(pg_pol) ? $past(power_good_int) : !$past(power_good_int)))
    else $error("power good polarity wrong");
  a_ctrl_off: assert property (!on_req |=> !output_enable)
    else $error("output on while control inactive");
  a_fault_sticky: assert property (oc_evt |=> fault_status && (host_alert == NOTIFY_EN))
    else $error("fast fault not flagged");
  a_ignore_runs: assert property (state == pofc_pkg::ST_RUN && on_req && oc_s &&
      act == pofc_pkg::ACT_IGNORE && !fault_clear |=> output_enable && current_clamp)
    else $error("ignore response left run");
  a_limit_latch: assert property (state == pofc_pkg::ST_LIMIT && oc_s && tmr_done &&
      on_req && retries == pofc_pkg::RETRY_NONE |=> state == pofc_pkg::ST_LATCHED ##1
      !output_enable)
    else $error("no-retry setting did not latch off");
  a_attempt_bound: assert property (retries != pofc_pkg::RETRY_FOREVER &&
      $stable(resp) |-> attempts <= retries)
    else $error("more restarts than programmed");
  a_clear_counter: assert property (fault_clear |=> attempts == 3'h0)
    else $error("attempt counter kept after clear");
  a_attempt_off: assert property (state == pofc_pkg::ST_OFF |=> attempts == 3'h0)
    else $error("attempt counter kept while off");
  a_retry_dark: assert property (state == pofc_pkg::ST_RETRY_WAIT |-> !output_enable)
    else $error("output on during retry wait");

  // limit registers: a write lands at the taking edge, a read shows it next cycle
  a_fast_store: assert property (wr && hit_fast |=>
      fast_limit == $past(cmd.data[15:0]))
    else $error("fast limit write lost");
  a_avg_store: assert property (wr && hit_avg |=>
      avg_limit == $past(cmd.data[15:0]))
    else $error("averaged limit write lost");
  a_fast_read: assert property (cmd.valid && !cmd.write && hit_fast |=>
      rd_valid && rd_data == {24'h0, $past(fast_limit)})
    else $error("fast limit read back wrong");

  // main scenarios the bench is meant to reach
  c_ignore_clamp: cover property (current_clamp && act == pofc_pkg::ACT_IGNORE);
  c_immediate: cover property (state == pofc_pkg::ST_RUN && oc_s && act == 2'h1);
  c_latched: cover property (state == pofc_pkg::ST_LATCHED);
  c_restart: cover property (state == pofc_pkg::ST_RETRY_WAIT ##[1:1000]
      state == pofc_pkg::ST_RUN);
  c_strap_addr: cover property (strap_en && target_address != base_w);

endmodule

// ==== bench/pofc_host_model.sv ====
// Purpose: host controller model issuing whole-register commands to the fault config block
// Assumes: one command in flight; read answer shows one cycle after the command cycle
// Notes:   released command fields carry inverted values so stale data cannot look valid
`timescale 1ns/1ps
module pofc_host_model (
  input  wire logic           clk,
  output pofc_pkg::pofc_cmd_t cmd,
  input  wire logic           rd_valid,
  input  wire logic           rd_unmapped,
  input  wire logic [39:0]    rd_data
);
  // ==========================================================================
  // idle bus at time zero
  initial cmd = '0;

  // ==========================================================================
  // one access: raise after an edge, hold through the taking edge, then sample
  // the bench programs many random target addresses; no pin or address clash is modelled
  task automatic access(input logic wr, input logic [7:0] code, input logic [39:0] data,
                        output logic [39:0] q, output logic vld, output logic unm);
    @(posedge clk);
    cmd <= '{valid: 1'b1, write: wr, code: code, data: data};
    @(posedge clk);
    cmd <= '{valid: 1'b0, write: ~wr, code: ~code, data: ~data};
    // answer is registered at the taking edge, so read it at the next one
    @(posedge clk);
    q   = rd_data;
    vld = rd_valid;
    unm = rd_unmapped;
  endtask
endmodule

// ==== bench/pmbus_oc_fault_config_bench.sv ====
// Purpose: self-checking bench of the overcurrent fault config block
// Assumes: MS_CYCLES shortened to 10 so a millisecond is ten clocks
// Notes:   run lengths are measured by a monitor with a small tolerance
`timescale 1ns/1ps
module pmbus_oc_fault_config_bench;
  localparam int MSC   = 10;
  localparam int LIMIT = 30000;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  pofc_pkg::pofc_cmd_t cmd;
  logic                oc = 1'b0, ctrl = 1'b0, bias = 1'b0, op_on = 1'b0;
  logic                oth = 1'b0, fclr = 1'b0, pg_int = 1'b0;
  logic [3:0]          s1 = 4'h0, s2 = 4'h0;
  logic                rd_valid, rd_unm, pg_pin, oen, clamp, fstat, alert;
  logic [39:0]         rd_data, q, d;
  logic [7:0]          taddr, off;
  logic [15:0]         avg_l, fast_l;
  logic                v, u, oen_q = 1'b0, clamp_q = 1'b0;
  int                  bad_count = 0, samples_checked = 0, cycles = 0, r0 = 0, dl = 0;
  int                  rises = 0, clamp_run = 0, clamp_len = 0, off_run = 0, off_len = 0;

  always #5 clk = ~clk;

  pofc_top #(.MS_CYCLES(MSC)) DUT (
    .cmd_valid_unused_guard(1'b0), .clk(clk), .rst_n(rst_n), .cmd(cmd),
    .oc_fast_detect(oc), .ctrl_pin(ctrl), .bias_ok(bias), .strap_address_input_one(s1),
    .strap_address_input_two(s2), .operation_on(op_on), .other_fault(oth),
    .fault_clear(fclr), .power_good_int(pg_int), .rd_valid(rd_valid), .rd_unmapped(rd_unm),
    .rd_data(rd_data), .target_address(taddr), .power_good_pin(pg_pin),
    .output_enable(oen), .current_clamp(clamp), .fault_status(fstat),
    .host_alert(alert), .avg_limit(avg_l), .fast_limit(fast_l)
  );

  pofc_host_model host (
    .clk(clk), .cmd(cmd), .rd_valid(rd_valid), .rd_unmapped(rd_unm), .rd_data(rd_data)
  );

  // ==========================================================================
  // monitor: restarts, clamp run and off run lengths, hang guard
  always @(posedge clk) begin
    cycles  <= cycles + 1;
    oen_q   <= oen;
    clamp_q <= clamp;
    clamp_run <= clamp ? clamp_run + 1 : 0;
    off_run   <= oen ? 0 : off_run + 1;
    if (oen && !oen_q) begin
      rises   <= rises + 1;
      off_len <= off_run;
    end
    if (!clamp && clamp_q) clamp_len <= clamp_run;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("MISMATCH timeout expected done seen running");
      conclude();
    end
  end

  // ==========================================================================
  // comparisons and bus helpers
  task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // timers may land up to three cycles off the nominal edge
  task automatic near(input string name, input int exp, input int got);
    samples_checked++;
    if (got < exp - 3 || got > exp + 3) begin
      bad_count++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [39:0] dat);
    host.access(1'b1, c, dat, q, v, u);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] c, input logic [39:0] exp);
    host.access(1'b0, c, 40'h0, q, v, u);
    check({name, " valid"}, 40'h1, {39'h0, v});
    check(name, exp, q);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic int dly(input logic [1:0] unit, input logic [2:0] t);
    logic [3:0] sh;
    sh = unit == 2'h0 ? pofc_pkg::DU_SHIFT_1MS : unit == 2'h1 ? pofc_pkg::DU_SHIFT_4MS :
         unit == 2'h2 ? pofc_pkg::DU_SHIFT_16MS : pofc_pkg::DU_SHIFT_256MS;
    return (1 << (sh + t)) * MSC;
  endfunction
  // program response, power up, then hold the fault for a window
  task automatic fault_run(input logic [1:0] act, input logic [2:0] rty,
                           input logic [1:0] unit, input logic [2:0] t, input int win);
    wr(pofc_pkg::CMD_DELAY_UNIT, {32'h0, 4'h0, unit, 2'h0});
    wr(pofc_pkg::CMD_OC_RESP, {32'h0, act, rty, t});
    @(posedge clk) begin
      ctrl  <= 1'b1;
      op_on <= 1'b1;
      bias  <= 1'b1;
    end
    wait_cyc(6);
    check("output on", 40'h1, {39'h0, oen});
    r0 = rises;
    @(posedge clk) oc <= 1'b1;
    wait_cyc(win);
  endtask
  // drop the fault, pulse clear, expect the output back
  task automatic recover();
    @(posedge clk) begin
      oc   <= 1'b0;
      oth  <= 1'b0;
      fclr <= 1'b1;
    end
    @(posedge clk) fclr <= 1'b0;
    wait_cyc(8);
    check("on after clear", 40'h1, {39'h0, oen});
    check("status cleared", 40'h0, {38'h0, fstat, alert});
  endtask
  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'h42a17157));
    wait_cyc(19);
    @(posedge clk) rst_n <= 1'b1;
    // reset values and an unmapped code
    rd_chk("cfg reset", pofc_pkg::CMD_ADDR_CFG, 40'h0);
    rd_chk("resp reset", pofc_pkg::CMD_OC_RESP, 40'h0);
    rd_chk("unit reset", pofc_pkg::CMD_DELAY_UNIT, 40'h0);
    rd_chk("avg reset", pofc_pkg::CMD_AVG_LIMIT, 40'h0);
    rd_chk("fast reset", pofc_pkg::CMD_FAST_LIMIT, 40'h0);
    host.access(1'b0, 8'hcb, 40'h0, q, v, u);
    check("unmapped flag", 40'h1, {39'h0, u});
    check("unmapped data", 40'h0, q);
    $display("test reset done");
    // random register contents, address and power-good polarity
    repeat (16) begin
      d = 40'({$urandom, $urandom});
      @(posedge clk) begin
        s1     <= 4'($urandom);
        s2     <= 4'($urandom);
        pg_int <= 1'($urandom);
      end
      wr(pofc_pkg::CMD_ADDR_CFG, d);
      wr(pofc_pkg::CMD_OC_RESP, ~d);
      wr(pofc_pkg::CMD_AVG_LIMIT, d >> 8);
      wr(pofc_pkg::CMD_FAST_LIMIT, d >> 16);
      wr(pofc_pkg::CMD_DELAY_UNIT, d >> 24);
      rd_chk("cfg", pofc_pkg::CMD_ADDR_CFG, d & pofc_pkg::CFG_RW_MASK);
      rd_chk("resp", pofc_pkg::CMD_OC_RESP, {32'h0, ~d[7:0]});
      rd_chk("unit", pofc_pkg::CMD_DELAY_UNIT, {32'h0, d[31:24]});
      rd_chk("avg", pofc_pkg::CMD_AVG_LIMIT, {24'h0, d[23:8]});
      rd_chk("fast", pofc_pkg::CMD_FAST_LIMIT, {24'h0, d[31:16]});
      check("fast port", {24'h0, d[31:16]}, {24'h0, fast_l});
      check("avg port", {24'h0, d[23:8]}, {24'h0, avg_l});
      off = d[16] ? {1'b0, s2[2:0], s1} : {1'b0, d[23:17]};
      check("address", {32'h0, d[31:24] + off}, {32'h0, taddr});
      check("pg pin", {39'h0, d[39] ? pg_int : ~pg_int}, {39'h0, pg_pin});
    end
    $display("test registers done");
    // active-low control polarity: low pin means on
    wr(pofc_pkg::CMD_ADDR_CFG, 40'h00_0000_0000);
    @(posedge clk) begin
      op_on <= 1'b1;
      bias  <= 1'b1;
    end
    wait_cyc(6);
    check("low pol on", 40'h1, {39'h0, oen});
    @(posedge clk) ctrl <= 1'b1;
    wait_cyc(6);
    check("low pol off", 40'h0, {39'h0, oen});
    wr(pofc_pkg::CMD_ADDR_CFG, 40'h01_0000_0000);
    // ignore code: keeps running and clamping, status and alert raised
    fault_run(pofc_pkg::ACT_IGNORE, 3'h3, 2'h0, 3'h0, 300);
    check("ignore on", 40'h1, {39'h0, oen});
    check("ignore clamp", 40'h1, {39'h0, clamp});
    check("status", 40'h1, {39'h0, fstat});
    check("alert", 40'h1, {39'h0, alert});
    recover();
    $display("test ignore done");
    // every delay unit, no retry: limit for the delay, then latch off
    for (int k = 0; k < 4; k++) begin
      dl = dly(2'(k), 3'h0);
      fault_run(pofc_pkg::ACT_SHUT_RETRY, pofc_pkg::RETRY_NONE, 2'(k), 3'h0, dl + 40);
      near("limit time", dl, clamp_len);
      check("no restart", 40'h0, 40'(rises - r0));
      check("latched", 40'h0, {39'h0, oen});
      recover();
    end
    // codes 01 and 10 shut down at once with no limiting delay
    for (int a = 1; a < 3; a++) begin
      fault_run(2'(a), pofc_pkg::RETRY_NONE, 2'h0, 3'h0, 20);
      check("immediate off", 40'h0, {39'h0, oen});
      check("no limiting", 40'h0, {39'h0, clamp});
      check("status any code", 40'h1, {39'h0, fstat});
      recover();
    end
    $display("test units done");
    // finite retries with their spacing
    for (int r = 1; r < 7; r++) begin
      dl = dly(2'h0, 3'h1);
      fault_run(pofc_pkg::ACT_SHUT_RETRY, 3'(r), 2'h0, 3'h1, (2 * r + 1) * dl + 60);
      check("restarts", 40'(r), 40'(rises - r0));
      near("retry spacing", dl, off_len);
      check("off after retries", 40'h0, {39'h0, oen});
      recover();
    end
    // clearing restores the full count without an off/on cycle
    r0 = rises;
    @(posedge clk) oc <= 1'b1;
    wait_cyc(13 * dl + 60);
    check("full count again", 40'h6, 40'(rises - r0));
    recover();
    $display("test retries done");
    // endless retry until another fault stops it
    fault_run(pofc_pkg::ACT_SHUT_RETRY, pofc_pkg::RETRY_FOREVER, 2'h0, 3'h0, 300);
    check("many restarts", 40'h1, {39'h0, (rises - r0) > 8});
    @(posedge clk) oth <= 1'b1;
    wait_cyc(6);
    r0 = rises;
    wait_cyc(60);
    check("stopped", 40'h0, 40'(rises - r0));
    check("stopped off", 40'h0, {39'h0, oen});
    recover();
    $display("test endless retry done");
    conclude();
  end
endmodule
